// >>> rtl/irq_ctrl_pkg.sv
// constants and types for the two-level interrupt controller
// assumes a 32-bit AHB-Lite register bus on hclk
`default_nettype none
package irq_ctrl_pkg;
    // ========================================
    // register byte offsets
    localparam logic [7:0] OFS_IRQ_CONTROL_MAIN = 8'h00;
    localparam logic [7:0] OFS_IRQ_CONTROL_SECOND = 8'h04;
    localparam logic [7:0] OFS_RESET_CONTROL = 8'h08;
    localparam logic [7:0] OFS_PERIPH_FLAGS_SECOND = 8'h0C;
    localparam logic [7:0] OFS_PERIPH_ENABLE_SECOND = 8'h10;
    localparam logic [7:0] OFS_PERIPH_PRIORITY_SECOND = 8'h14;
    localparam logic [7:0] OFS_CORE_STATUS = 8'h18;
    // ========================================
    // field positions
    localparam int BIT_GLOBAL = 7;
    localparam int BIT_PERIPH = 6;
    localparam int BIT_TMR0_EN = 5;
    localparam int BIT_EXT0_EN = 4;
    localparam int BIT_PORT_EN = 3;
    localparam int BIT_TMR0_FLAG = 2;
    localparam int BIT_EXT0_FLAG = 1;
    localparam int BIT_PORT_FLAG = 0;
    localparam int BIT_PRIO_LEVELS = 7;
    localparam int BIT_EXT0_EDGE = 6;
    localparam int BIT_TMR0_PRIO = 2;
    localparam int BIT_PORT_PRIO = 0;
    localparam int BIT_USB = 5;
    // ========================================
    // reset values
    localparam logic [7:0] RST_MAIN = 8'h00;
    localparam logic [7:0] RST_SECOND = 8'h45;
    localparam logic [7:0] RST_RESET_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPH_FLAGS = 8'h00;
    localparam logic [7:0] RST_PERIPH_ENABLE = 8'h00;
    localparam logic [7:0] RST_PERIPH_PRIORITY = 8'h20;
    localparam logic [7:0] SECOND_MASK = 8'h45;
    localparam logic [7:0] PER2_MASK = 8'h20;
    // ========================================
    // vectors and timing
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam int PIN_SYNC_CYCLES = 2;
    localparam logic [1:0] SVC_NONE = 2'h0;
    typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_LOAD} seq_state_t;
endpackage
`default_nettype wire

// >>> rtl/two_level_irq_ctrl.sv
// two-level interrupt controller with AHB-Lite register slave
// assumes the core gives instruction-boundary and return strobes on hclk
//
// How it works
// - high vector 08h, low vector 18h
// - high request preempts running low routine
// - each source has flag, enable, priority; ext0 priority fixed high
// - priority_levels_enable splits global enables high/low
// - flag, enable, global enable all set vectors
// - priorities ignored in compatibility mode, vector 08h
// - compatibility: bit6 gates peripherals, bit7 all
// - acceptance clears the admitting global enable
// - no low service during high routine
// - push return address, then load vector
// - return sets cleared global enable again
// - pin event latency three to four cycles
// - flags set regardless of any enable
// - usb events funnel into one flag
// - bit6 gates all low-priority requests, bit7 clear blocks
// - main register enables 5..3, flags 2..0
// - timer flag sticky until software clears
// - port change flag set while pin mismatch persists, sticky after
// - external pin flag sticky until cleared
// - edge select: one rising, zero falling
//
// The address map and the AHB-Lite register port are this design's own decisions.
`default_nettype none
module two_level_irq_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int PC_W = 21
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic timer_zero_overflow,
    input wire logic ext_pin_zero,
    input wire logic [3:0] port_b_upper_pins,
    input wire logic port_b_read,
    input wire logic usb_event,
    input wire logic instr_boundary,
    input wire logic return_from_irq_instr,
    input wire logic [PC_W-1:0] return_address,
    output logic stack_push,
    output logic [PC_W-1:0] stack_push_data,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_value,
    output logic [1:0] service_level
);
    // ========================================
    // state
    typedef struct packed {
        logic [7:0] main;
        logic [7:0] second;
        logic [7:0] reset_ctl;
        logic [7:0] periph_flags;
        logic [7:0] periph_en;
        logic [7:0] periph_prio;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [3:0] port_sync1;
        logic [3:0] port_sync2;
        logic [3:0] port_latch;
        logic port_read_d;
        logic usb_prev;
        logic high_active;
        logic low_active;
        seq_state_t st;
        logic [PC_W-1:0] vec;
        logic [PC_W-1:0] ret;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } state_t;

    state_t s_r, s_nxt;

    function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            OFS_IRQ_CONTROL_MAIN: v = s.main;
            OFS_IRQ_CONTROL_SECOND: v = s.second;
            OFS_RESET_CONTROL: v = s.reset_ctl;
            OFS_PERIPH_FLAGS_SECOND: v = s.periph_flags;
            OFS_PERIPH_ENABLE_SECOND: v = s.periph_en;
            OFS_PERIPH_PRIORITY_SECOND: v = s.periph_prio;
            OFS_CORE_STATUS: v = {6'h00, s.low_active, s.high_active};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    logic ext_rise, ext_fall, ext_event, port_mismatch, usb_rise;
    logic req_high, req_low, take_high, take_low;
    logic prio_on, ge_high, ge_low;
    logic [2:0] src_pend;
    logic [2:0] src_prio;
    logic per_pend, per_prio;
    logic [7:0] wmain;

    always_comb begin
        s_nxt = s_r;
        prio_on = s_r.reset_ctl[BIT_PRIO_LEVELS];
        ge_high = s_r.main[BIT_GLOBAL];
        ge_low = s_r.main[BIT_PERIPH];
        // ========================================
        // source event detection
        ext_rise = s_r.ext_sync[1] & ~s_r.ext_prev;
        ext_fall = ~s_r.ext_sync[1] & s_r.ext_prev;
        ext_event = s_r.second[BIT_EXT0_EDGE] ? ext_rise : ext_fall;
        port_mismatch = |(s_r.port_sync2 ^ s_r.port_latch);
        usb_rise = usb_event & ~s_r.usb_prev;
        s_nxt.ext_sync = {s_r.ext_sync[0], ext_pin_zero};
        s_nxt.ext_prev = s_r.ext_sync[1];
        s_nxt.port_sync1 = port_b_upper_pins;
        s_nxt.port_sync2 = s_r.port_sync1;
        s_nxt.usb_prev = usb_event;
        // reading the port relatches after one cycle
        s_nxt.port_read_d = port_b_read;
        if (s_r.port_read_d) begin
            s_nxt.port_latch = s_r.port_sync2;
        end
        // ========================================
        // bus slave: address phase capture, data phase act
        s_nxt.ap_valid = hsel & hready & htrans[1];
        s_nxt.ap_write = hwrite;
        s_nxt.ap_addr = {haddr[7:2], 2'b00};
        wmain = s_r.main;
        if (s_r.ap_valid && s_r.ap_write) begin
            unique case (s_r.ap_addr)
                OFS_IRQ_CONTROL_MAIN: wmain = hwdata[7:0];
                OFS_IRQ_CONTROL_SECOND: s_nxt.second = hwdata[7:0] & SECOND_MASK;
                OFS_RESET_CONTROL: s_nxt.reset_ctl = {hwdata[BIT_PRIO_LEVELS], 7'h00};
                OFS_PERIPH_FLAGS_SECOND: s_nxt.periph_flags = hwdata[7:0] & PER2_MASK;
                OFS_PERIPH_ENABLE_SECOND: s_nxt.periph_en = hwdata[7:0] & PER2_MASK;
                OFS_PERIPH_PRIORITY_SECOND: s_nxt.periph_prio = hwdata[7:0] & PER2_MASK;
                default: ;
            endcase
        end
        s_nxt.rdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite) begin
            s_nxt.rdata = {24'h000000, reg_read(s_r, {haddr[7:2], 2'b00})};
        end
        // ========================================
        // flags: hardware set wins over software clear
        s_nxt.main = wmain;
        if (timer_zero_overflow) begin
            s_nxt.main[BIT_TMR0_FLAG] = 1'b1;
        end
        if (ext_event) begin
            s_nxt.main[BIT_EXT0_FLAG] = 1'b1;
        end
        if (port_mismatch) begin
            s_nxt.main[BIT_PORT_FLAG] = 1'b1;
        end
        if (usb_rise) begin
            s_nxt.periph_flags[BIT_USB] = 1'b1;
        end
        // ========================================
        // request qualification
        src_pend[0] = s_r.main[BIT_TMR0_FLAG] & s_r.main[BIT_TMR0_EN];
        src_pend[1] = s_r.main[BIT_EXT0_FLAG] & s_r.main[BIT_EXT0_EN];
        src_pend[2] = s_r.main[BIT_PORT_FLAG] & s_r.main[BIT_PORT_EN];
        src_prio[0] = s_r.second[BIT_TMR0_PRIO];
        src_prio[1] = 1'b1;
        src_prio[2] = s_r.second[BIT_PORT_PRIO];
        per_pend = s_r.periph_flags[BIT_USB] & s_r.periph_en[BIT_USB];
        per_prio = s_r.periph_prio[BIT_USB];
        if (prio_on) begin
            req_high = ge_high & ((|(src_pend & src_prio)) | (per_pend & per_prio));
            req_low = ge_high & ge_low & ((|(src_pend & ~src_prio)) | (per_pend & ~per_prio));
        end else begin
            req_high = ge_high & ((|src_pend) | (per_pend & ge_low));
            req_low = 1'b0;
        end
        take_high = req_high & ~s_r.high_active;
        take_low = req_low & ~s_r.high_active & ~s_r.low_active;
        // ========================================
        // entry sequence at instruction boundary
        unique case (s_r.st)
            ST_RUN: begin
                if (instr_boundary && (take_high || take_low)) begin
                    s_nxt.st = ST_PUSH;
                    s_nxt.ret = return_address;
                    s_nxt.vec = (take_high || !prio_on) ? VEC_HIGH : VEC_LOW;
                    if (take_high) begin
                        s_nxt.main[BIT_GLOBAL] = 1'b0;
                        s_nxt.high_active = 1'b1;
                    end else begin
                        s_nxt.main[BIT_PERIPH] = 1'b0;
                        s_nxt.low_active = 1'b1;
                    end
                end else if (return_from_irq_instr) begin
                    if (s_r.high_active) begin
                        s_nxt.main[BIT_GLOBAL] = 1'b1;
                        s_nxt.high_active = 1'b0;
                    end else if (s_r.low_active) begin
                        s_nxt.main[prio_on ? BIT_PERIPH : BIT_GLOBAL] = 1'b1;
                        s_nxt.low_active = 1'b0;
                    end
                end
            end
            ST_PUSH: s_nxt.st = ST_LOAD;
            ST_LOAD: s_nxt.st = ST_RUN;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '{main: RST_MAIN, second: RST_SECOND, reset_ctl: RST_RESET_CONTROL,
                periph_flags: RST_PERIPH_FLAGS, periph_en: RST_PERIPH_ENABLE,
                periph_prio: RST_PERIPH_PRIORITY, st: ST_RUN, vec: '0, ret: '0,
                rdata: 32'h0000_0000, ap_addr: 8'h00, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ========================================
    // outputs
    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign stack_push = (s_r.st == ST_PUSH);
    assign stack_push_data = s_r.ret;
    assign pc_load = (s_r.st == ST_LOAD);
    assign pc_load_value = s_r.vec;
    assign service_level = {s_r.low_active, s_r.high_active};
endmodule
`default_nettype wire

// >>> testbench/irq_ctrl_properties.sv
// port-level checks of the interrupt sequencing outputs
// assumes it is bound into two_level_irq_ctrl
`default_nettype none
module irq_ctrl_properties
    import irq_ctrl_pkg::*;
#(
    parameter int PC_W = 21
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic instr_boundary,
    input wire logic [PC_W-1:0] return_address,
    input wire logic stack_push,
    input wire logic [PC_W-1:0] stack_push_data,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_load_value,
    input wire logic [1:0] service_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ========================================
    // entry sequence
    property p_push_load; stack_push |=> pc_load; endproperty
    a_push_load: assert property (p_push_load) else $error("no load after push");
    property p_load_past; pc_load |-> $past(stack_push); endproperty
    a_load_past: assert property (p_load_past) else $error("load without push");
    property p_push_pulse; stack_push |=> !stack_push ##1 !stack_push; endproperty
    a_push_pulse: assert property (p_push_pulse) else $error("push too long");
    property p_push_data; stack_push |-> stack_push_data == $past(return_address); endproperty
    a_push_data: assert property (p_push_data) else $error("wrong return address");
    property p_boundary; stack_push |-> $past(instr_boundary); endproperty
    a_boundary: assert property (p_boundary) else $error("accept off boundary");
    property p_load_vec; pc_load |-> pc_load_value == VEC_HIGH || pc_load_value == VEC_LOW; endproperty
    a_load_vec: assert property (p_load_vec) else $error("bad vector");
    // ========================================
    // service levels
    property p_low_level; pc_load && pc_load_value == VEC_LOW |-> service_level[1]; endproperty
    a_low_level: assert property (p_low_level) else $error("low level not marked");
    property p_no_low; $rose(service_level[1]) |-> !$past(service_level[0]); endproperty
    a_no_low: assert property (p_no_low) else $error("low under high");
    c_high: cover property (pc_load && pc_load_value == VEC_HIGH);
    c_low: cover property (pc_load && pc_load_value == VEC_LOW);
    c_nest: cover property (service_level == 2'h3);
endmodule
bind two_level_irq_ctrl irq_ctrl_properties #(.PC_W(PC_W)) u_props (.hclk(hclk), .hresetn(hresetn),
    .instr_boundary(instr_boundary), .return_address(return_address), .stack_push(stack_push),
    .stack_push_data(stack_push_data), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .service_level(service_level));
`default_nettype wire

// >>> testbench/core_seq_model.sv
// behavioural program sequencer facing the controller
// assumes one cycle per instruction, or two when two_cycle is set
`default_nettype none
module core_seq_model #(
    parameter int PC_W = 21
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic two_cycle,
    input wire logic ret_req,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_load_value,
    output logic instr_boundary,
    output logic return_from_irq_instr,
    output logic [PC_W-1:0] return_address
);
    timeunit 1ns;
    timeprecision 1ns;
    logic phase_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= 1'b0;
            return_address <= '0;
        end else begin
            phase_r <= two_cycle ? !phase_r : 1'b0;
            if (pc_load) begin
                return_address <= pc_load_value;
            end else if (instr_boundary) begin
                return_address <= return_address + 1'b1;
            end
        end
    end
    assign instr_boundary = hresetn && (!two_cycle || phase_r);
    assign return_from_irq_instr = ret_req && instr_boundary;
endmodule
`default_nettype wire

// >>> testbench/two_level_interrupt_controller_tb_top.sv
// self-checking bench for the two-level interrupt controller
// assumes the core model and the bound checker
`default_nettype none
module two_level_interrupt_controller_tb_top
    import irq_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, timer_zero_overflow = 1'b0;
    logic ext_pin_zero = 1'b0, port_b_read = 1'b0, usb_event = 1'b0, ret_req = 1'b0, two_cycle = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic [3:0] port_b_upper_pins = 4'h0;
    logic hreadyout, hresp, instr_boundary, return_from_irq_instr, stack_push, pc_load;
    logic [20:0] return_address, stack_push_data, pc_load_value;
    logic [1:0] service_level;
    int err_total = 0, cmp_count = 0;
    always #25 hclk = ~hclk;
    two_level_irq_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .timer_zero_overflow, .ext_pin_zero,
        .port_b_upper_pins, .port_b_read, .usb_event, .instr_boundary, .return_from_irq_instr,
        .return_address, .stack_push, .stack_push_data, .pc_load, .pc_load_value, .service_level);
    core_seq_model core (.hclk, .hresetn, .two_cycle, .ret_req, .pc_load, .pc_load_value,
        .instr_boundary, .return_from_irq_instr, .return_address);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, {24'h0, e});
    endtask
    // expect the last vector load within the 12-cycle window to be e, or none when e is zero
    task automatic vec(input logic [20:0] e);
        logic [20:0] v;
        v = '0;
        repeat (12) begin
            @(posedge hclk);
            if (pc_load === 1'b1) v = pc_load_value;
        end
        chk({11'h0, v}, {11'h0, e});
    endtask
    task automatic tick;
        @(posedge hclk);
        timer_zero_overflow <= 1'b1;
        @(posedge hclk);
        timer_zero_overflow <= 1'b0;
    endtask
    task automatic ret;
        @(posedge hclk);
        ret_req <= 1'b1;
        @(posedge hclk);
        ret_req <= 1'b0;
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        results;
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_IRQ_CONTROL_MAIN, RST_MAIN);
        rd(OFS_IRQ_CONTROL_SECOND, RST_SECOND);
        rd(OFS_RESET_CONTROL, RST_RESET_CONTROL);
        rd(OFS_PERIPH_PRIORITY_SECOND, RST_PERIPH_PRIORITY);
        rd(8'h1C, 8'h00);
        tick;
        vec(21'h0);
        rd(OFS_IRQ_CONTROL_MAIN, 8'h04);
        wr(OFS_IRQ_CONTROL_MAIN, 8'h00);
        rd(OFS_IRQ_CONTROL_MAIN, 8'h00);
        ext_pin_zero <= 1'b1;
        vec(21'h0);
        rd(OFS_IRQ_CONTROL_MAIN, 8'h02);
        wr(OFS_IRQ_CONTROL_SECOND, 8'h05);
        wr(OFS_IRQ_CONTROL_MAIN, 8'h00);
        ext_pin_zero <= 1'b0;
        vec(21'h0);
        rd(OFS_IRQ_CONTROL_MAIN, 8'h02);
        port_b_upper_pins <= 4'h5;
        vec(21'h0);
        wr(OFS_IRQ_CONTROL_MAIN, 8'h00);
        rd(OFS_IRQ_CONTROL_MAIN, 8'h01);
        port_b_read <= 1'b1;
        @(posedge hclk);
        port_b_read <= 1'b0;
        vec(21'h0);
        wr(OFS_IRQ_CONTROL_MAIN, 8'h00);
        rd(OFS_IRQ_CONTROL_MAIN, 8'h00);
        // compatibility mode: priority bits ignored
        wr(OFS_IRQ_CONTROL_SECOND, 8'h41);
        wr(OFS_IRQ_CONTROL_MAIN, 8'hA0);
        tick;
        vec(VEC_HIGH);
        rd(OFS_IRQ_CONTROL_MAIN, 8'h24);
        wr(OFS_IRQ_CONTROL_MAIN, 8'h20);
        ret;
        rd(OFS_IRQ_CONTROL_MAIN, 8'hA0);
        wr(OFS_PERIPH_ENABLE_SECOND, 8'h20);
        usb_event <= 1'b1;
        vec(21'h0);
        rd(OFS_PERIPH_FLAGS_SECOND, 8'h20);
        wr(OFS_IRQ_CONTROL_MAIN, 8'hE0);
        vec(VEC_HIGH);
        rd(OFS_IRQ_CONTROL_MAIN, 8'h60);
        wr(OFS_PERIPH_FLAGS_SECOND, 8'h00);
        usb_event <= 1'b0;
        wr(OFS_PERIPH_ENABLE_SECOND, 8'h00);
        ret;
        rd(OFS_IRQ_CONTROL_MAIN, 8'hE0);
        // priority mode on a slow core: low entry, then high preempts
        two_cycle <= 1'b1;
        wr(OFS_RESET_CONTROL, 8'h80);
        tick;
        vec(VEC_LOW);
        rd(OFS_IRQ_CONTROL_MAIN, 8'hA4);
        rd(OFS_CORE_STATUS, 8'h02);
        wr(OFS_IRQ_CONTROL_MAIN, 8'hB0);
        ext_pin_zero <= 1'b1;
        vec(VEC_HIGH);
        rd(OFS_CORE_STATUS, 8'h03);
        wr(OFS_IRQ_CONTROL_MAIN, 8'hE0);
        tick;
        vec(21'h0);
        results;
    end
endmodule
`default_nettype wire
